// ==== rtl/cwg_core.sv ====
// Implementation choices: strobed register access and the address map.
module cwg_core
   import cwg_pkg::*;
(
   input  wire logic          clk,              // system clock
   input  wire logic          nrst,             // async reset, active low
   input  wire logic          fast_osc_tick,    // fast oscillator rate, async
   input  wire logic          sleep_req,        // cpu asleep
   input  wire logic [2:0]    addr,             // register index
   input  wire logic [7:0]    wdata,            // write data
   input  wire logic          wr,               // write strobe
   input  wire logic          rd,               // read strobe
   output      logic [7:0]    rdata,            // read data, cycle after rd
   input  wire cwg_pkg::cwg_src_s src_in,       // waveform sources, async
   input  wire logic          fault_input_pin,  // fault pin, async
   input  wire logic          second_logic_cell_output, // async
   output      cwg_pkg::cwg_pin_s output_a,     // pin a level and enable
   output      cwg_pkg::cwg_pin_s output_b,     // pin b level and enable
   output      logic          fast_osc_keep     // keep fast oscillator alive
);
   import cwg_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl0;          // enable, polarity, clock
   logic [7:0] ctrl1;          // overrides, source
   logic [5:0] rising_deadband_count;
   logic [5:0] falling_deadband_count;
   logic       auto_restart_enable;
   logic       fault_pin_shutdown_enable;
   logic       logic_cell_shutdown_enable;
   logic       shutdown_status_bit;

   // field views
   logic       module_enable_bit;
   logic       output_a_enable, output_b_enable;
   logic       output_a_polarity, output_b_polarity;
   logic       clock_source_select;
   logic [2:0] input_source_select;
   logic [1:0] override_level_a, override_level_b;

   assign module_enable_bit   = ctrl0[BIT_EN];
   assign output_b_enable     = ctrl0[BIT_OEB];
   assign output_a_enable     = ctrl0[BIT_OEA];
   assign output_b_polarity   = ctrl0[BIT_POLB];
   assign output_a_polarity   = ctrl0[BIT_POLA];
   assign clock_source_select = ctrl0[BIT_CS];
   assign override_level_b    = ctrl1[LSB_OVB +: 2];
   assign override_level_a    = ctrl1[LSB_OVA +: 2];
   assign input_source_select = ctrl1[LSB_IS +: 3];

   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   logic [8:0] sync1, sync2;   // two-stage for all async inputs
   logic [8:0] raw_in;

   assign raw_in = {fast_osc_tick, fault_input_pin, second_logic_cell_output,
                    src_in};

   // two flops per async input before any use
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
      end
      else
      begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   logic [5:0] src_s;      // synced sources
   logic       flt_s;      // synced fault pin
   logic       lc2_s;      // synced logic cell 2
   logic       osc_s;      // synced fast oscillator
   assign src_s = sync2[5:0];
   assign lc2_s = sync2[6];
   assign flt_s = sync2[7];
   assign osc_s = sync2[8];

   // ---------------------------------------------------------------
   // source select and dead band tick
   // ---------------------------------------------------------------
   function automatic logic pick_src(input logic [2:0] sel, input logic [5:0] s);
      logic r;
      r = 1'b0;
      unique case (sel)
         SRC_PWM1: r = s[0];
         SRC_PWM2: r = s[1];
         SRC_PWM3: r = s[2];
         SRC_PWM4: r = s[3];
         SRC_OSC:  r = s[4];
         SRC_LC1:  r = s[5];
         default:  r = 1'b0;  // reserved codes give a quiet source
      endcase
      return r;
   endfunction

   logic in_lvl;     // selected source level
   logic in_q;       // previous level
   logic osc_q;      // previous oscillator level
   logic tick;       // dead band count enable
   logic rise, fall; // edges of selected source

   assign in_lvl = pick_src(input_source_select, src_s);
   assign rise   = in_lvl & ~in_q;
   assign fall   = ~in_lvl & in_q;
   // system clock every cycle, or one per fast oscillator rising edge
   assign tick   = clock_source_select ? (osc_s & ~osc_q) : 1'b1;

   // edge history
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         in_q  <= 1'b0;
         osc_q <= 1'b0;
      end
      else
      begin
         in_q  <= in_lvl;
         osc_q <= osc_s;
      end
   end

   // ---------------------------------------------------------------
   // dead band state machine
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CWG_IDLE   = 2'b00,  // both drives settled
      CWG_RISE   = 2'b01,  // counting before a turns on
      CWG_FALL   = 2'b10   // counting before b turns on
   } cwg_db_e;

   cwg_db_e    db_state;
   logic [6:0] db_cnt;     // counts up to the field value
   logic       drive_a;    // internal a drive, active high
   logic       drive_b;    // internal b drive, active high

   // edges abort a pending count; new edge restarts opposite count
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         db_state <= CWG_IDLE;
         db_cnt   <= 7'h00;
         drive_a  <= 1'b0;
         drive_b  <= 1'b0;
      end
      else if (!module_enable_bit)
      begin
         db_state <= CWG_IDLE;
         db_cnt   <= 7'h00;
         drive_a  <= 1'b0;
         drive_b  <= 1'b0;
      end
      else if (rise)
      begin
         drive_b <= 1'b0;
         db_cnt  <= 7'h00;
         if (rising_deadband_count == 6'h00)
         begin
            drive_a  <= 1'b1;  // bypass
            db_state <= CWG_IDLE;
         end
         else
         begin
            db_state <= CWG_RISE;  // a stays off, pending b cancelled
         end
      end
      else if (fall)
      begin
         drive_a <= 1'b0;
         db_cnt  <= 7'h00;
         if (falling_deadband_count == 6'h00)
         begin
            drive_b  <= 1'b1;
            db_state <= CWG_IDLE;
         end
         else
         begin
            db_state <= CWG_FALL;
         end
      end
      else
      begin
         unique case (db_state)
            CWG_IDLE: ;
            CWG_RISE:
            begin
               if (tick)
               begin
                  if (db_cnt[5:0] == rising_deadband_count - 6'h01)
                  begin
                     drive_a  <= 1'b1;
                     db_state <= CWG_IDLE;
                  end
                  db_cnt <= db_cnt + 7'h01;
               end
            end
            CWG_FALL:
            begin
               if (tick)
               begin
                  if (db_cnt[5:0] == falling_deadband_count - 6'h01)
                  begin
                     drive_b  <= 1'b1;
                     db_state <= CWG_IDLE;
                  end
                  db_cnt <= db_cnt + 7'h01;
               end
            end
            default:
            begin
               db_state <= CWG_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // shutdown
   // ---------------------------------------------------------------
   logic src_active;   // any enabled source active
   logic hold_ovr;     // overrides held until next rising edge

   assign src_active = (fault_pin_shutdown_enable & ~flt_s)
                     | (logic_cell_shutdown_enable & lc2_s);

   // overrides persist after status clears until a rising edge
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         hold_ovr <= 1'b0;
      else if (shutdown_status_bit)
         hold_ovr <= 1'b1;
      else if (rise)
         hold_ovr <= 1'b0;
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl0                  <= RST_CTRL0;
         ctrl1                  <= RST_CTRL1;
         rising_deadband_count  <= RST_DB[5:0];
         falling_deadband_count <= RST_DB[5:0];
      end
      else if (wr)
      begin
         unique case (addr)
            ADDR_CTRL0: ctrl0 <= wdata & MASK_CTRL0;
            ADDR_CTRL1: ctrl1 <= wdata & MASK_CTRL1;
            ADDR_DBR:   rising_deadband_count  <= wdata[5:0];
            ADDR_DBF:   falling_deadband_count <= wdata[5:0];
            default: ;
         endcase
      end
   end

   // shutdown control bits
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         auto_restart_enable        <= RST_CTRL2[BIT_ARS];
         fault_pin_shutdown_enable  <= RST_CTRL2[BIT_FLT];
         logic_cell_shutdown_enable <= RST_CTRL2[BIT_LC2];
      end
      else if (wr && addr == ADDR_CTRL2)
      begin
         auto_restart_enable        <= wdata[BIT_ARS];
         fault_pin_shutdown_enable  <= wdata[BIT_FLT];
         logic_cell_shutdown_enable <= wdata[BIT_LC2];
      end
   end

   // status: hardware set wins over any clear
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         shutdown_status_bit <= RST_CTRL2[BIT_ASE];
      else if (src_active)
         shutdown_status_bit <= 1'b1;
      else if (wr && addr == ADDR_CTRL2 && wdata[BIT_ASE])
         shutdown_status_bit <= 1'b1;
      else if (wr && addr == ADDR_CTRL2 && !wdata[BIT_ASE])
         shutdown_status_bit <= 1'b0;  // only reached when sources idle
      else if (auto_restart_enable)
         shutdown_status_bit <= 1'b0;
   end

   // ---------------------------------------------------------------
   // output stage
   // ---------------------------------------------------------------
   function automatic cwg_pin_s out_pin(input logic drv, input logic pol,
                                        input logic [1:0] ov, input logic ovr,
                                        input logic oe);
      cwg_pin_s p;
      p.level = drv ^ pol;
      p.oe    = oe;
      if (ovr)
      begin
         unique case (ov)
            CWG_OV_HIGH:     p.level = 1'b1;
            CWG_OV_LOW:      p.level = 1'b0;
            CWG_OV_TRISTATE: p.oe    = 1'b0;
            CWG_OV_INACTIVE: p.level = pol;   // inactive, polarity applies
         endcase
      end
      return p;
   endfunction

   logic ovr_now;  // override in force this cycle
   assign ovr_now = src_active | shutdown_status_bit | hold_ovr;

   // registered pins; enables gated by module enable
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         output_a <= '0;
         output_b <= '0;
      end
      else
      begin
         output_a <= out_pin(drive_a, output_a_polarity, override_level_a, ovr_now,
                             module_enable_bit & output_a_enable);
         output_b <= out_pin(drive_b, output_b_polarity, override_level_b, ovr_now,
                             module_enable_bit & output_b_enable);
      end
   end

   // fast oscillator request, only needed while the cpu sleeps
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         fast_osc_keep <= 1'b0;
      else
         fast_osc_keep <= module_enable_bit & clock_source_select & in_lvl & sleep_req;
   end

   // ---------------------------------------------------------------
   // register reads
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= 8'h00;
      else if (rd)
      begin
         unique case (addr)
            ADDR_CTRL0: rdata <= ctrl0;
            ADDR_CTRL1: rdata <= ctrl1;
            ADDR_CTRL2: rdata <= {shutdown_status_bit, auto_restart_enable, 4'h0,
                                  fault_pin_shutdown_enable,
                                  logic_cell_shutdown_enable};
            ADDR_DBR:   rdata <= {2'h0, rising_deadband_count};
            ADDR_DBF:   rdata <= {2'h0, falling_deadband_count};
            default:    rdata <= 8'h00;
         endcase
      end
      else
         rdata <= 8'h00;
   end

endmodule

// ==== shared/cwg_pkg.sv ====
package cwg_pkg;

   // ---------------------------------------------------------------
   // register map (word index on the plain register port)
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_CTRL0 = 3'h0;  // enable, polarity, clock select
   localparam logic [2:0] ADDR_CTRL1 = 3'h1;  // override levels, input source
   localparam logic [2:0] ADDR_CTRL2 = 3'h2;  // shutdown control
   localparam logic [2:0] ADDR_DBR   = 3'h3;  // rising dead band
   localparam logic [2:0] ADDR_DBF   = 3'h4;  // falling dead band

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_EN    = 7;  // module enable
   localparam int BIT_OEB   = 6;  // output b enable
   localparam int BIT_OEA   = 5;  // output a enable
   localparam int BIT_POLB  = 4;  // output b polarity
   localparam int BIT_POLA  = 3;  // output a polarity
   localparam int BIT_CS    = 0;  // clock select
   localparam int BIT_ASE   = 7;  // shutdown status
   localparam int BIT_ARS   = 6;  // auto restart
   localparam int BIT_FLT   = 1;  // fault pin shutdown enable
   localparam int BIT_LC2   = 0;  // logic cell shutdown enable
   localparam int LSB_OVB   = 6;  // override b field low bit
   localparam int LSB_OVA   = 4;  // override a field low bit
   localparam int LSB_IS    = 0;  // input source field low bit

   // ---------------------------------------------------------------
   // implemented-bit masks and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MASK_CTRL0  = 8'hF9;
   localparam logic [7:0] MASK_CTRL1  = 8'hF7;
   localparam logic [7:0] MASK_CTRL2  = 8'hC3;
   localparam logic [7:0] MASK_DB     = 8'h3F;
   localparam logic [7:0] RST_CTRL0   = 8'h00;
   localparam logic [7:0] RST_CTRL1   = 8'h00;
   localparam logic [7:0] RST_CTRL2   = 8'h00;
   localparam logic [7:0] RST_DB      = 8'h00;

   // override level codes
   typedef enum logic [1:0] {
      CWG_OV_INACTIVE = 2'h0,
      CWG_OV_TRISTATE = 2'h1,
      CWG_OV_LOW      = 2'h2,
      CWG_OV_HIGH     = 2'h3
   } cwg_ov_e;

   // input source codes
   localparam logic [2:0] SRC_PWM1 = 3'h2;
   localparam logic [2:0] SRC_PWM2 = 3'h3;
   localparam logic [2:0] SRC_PWM3 = 3'h4;
   localparam logic [2:0] SRC_PWM4 = 3'h5;
   localparam logic [2:0] SRC_OSC  = 3'h6;
   localparam logic [2:0] SRC_LC1  = 3'h7;

   // one pin: level plus output enable
   typedef struct packed {
      logic level;  // driven level
      logic oe;     // high while driven
   } cwg_pin_s;

   // candidate waveform sources
   typedef struct packed {
      logic lc1;    // first logic cell
      logic osc;    // oscillator output
      logic pwm4;
      logic pwm3;
      logic pwm2;
      logic pwm1;
   } cwg_src_s;

endpackage

// ==== testbench/cwg_core_checker.sv ====
module cwg_core_checker
   import cwg_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [2:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   input  wire logic [7:0]        rdata,
   input  wire logic              fault_input_pin,
   input  wire logic              second_logic_cell_output,
   input  wire cwg_pkg::cwg_pin_s output_a,
   input  wire cwg_pkg::cwg_pin_s output_b,
   input  wire logic              fast_osc_keep
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // shadow of software fields
   // ---------------------------------------------------------------
   logic [7:0] c0;       // enables, polarity, clock select
   logic [7:0] c1;       // override levels, source
   logic [1:0] c2;       // shutdown source enables
   logic [2:0] since_wr; // cycles since last write, saturating
   logic       settled;  // outputs have caught up with writes
   assign settled = (since_wr == 3'h7);
   // track writes as the block takes them
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         c0 <= 8'h00;
         c1 <= 8'h00;
         c2 <= 2'h0;
         since_wr <= 3'h0;
      end
      else if (wr)
      begin
         since_wr <= 3'h0;
         if (addr == ADDR_CTRL0)
            c0 <= wdata;
         if (addr == ADDR_CTRL1)
            c1 <= wdata;
         if (addr == ADDR_CTRL2)
            c2 <= wdata[1:0];
      end
      else if (!settled)
         since_wr <= since_wr + 3'h1;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   unmapped_read_a: assert property (rd && addr > 3'h4 |=> rdata == 8'h00)
      else $error("unmapped index read nonzero");
   ctrl0_rsvd_a: assert property (rd && addr == ADDR_CTRL0 |=> (rdata & ~MASK_CTRL0) == 8'h00)
      else $error("ctrl0 unused bits set");
   db_rsvd_a: assert property (rd && (addr == ADDR_DBR || addr == ADDR_DBF)
      |=> rdata[7:6] == 2'h0)
      else $error("dead band upper bits set");
   no_overlap_a: assert property (settled && c0[4:3] == 2'h0 && c1[7:6] != 2'h3
      && c1[5:4] != 2'h3 |-> !(output_a == 2'b11 && output_b == 2'b11))
      else $error("both outputs on");
   gate_a_a: assert property (settled && !(c0[7] && c0[5]) |-> !output_a.oe)
      else $error("output a driven while off");
   gate_b_a: assert property (settled && !(c0[7] && c0[6]) |-> !output_b.oe)
      else $error("output b driven while off");
   fault_shut_a: assert property ((settled && c0[7] && c0[5] && c2[1]
      && c1[5:4] == 2'h3 && !fault_input_pin)[*5] |-> output_a == 2'b11)
      else $error("fault did not force a high");
   cell_shut_a: assert property ((settled && c0[7] && c2[0] && c1[7:6] == 2'h1
      && second_logic_cell_output)[*5] |-> !output_b.oe)
      else $error("cell shutdown did not release b");
   status_hold_a: assert property ((settled && c0[7] && c2[1] && !fault_input_pin)[*4]
      ##0 (rd && addr == ADDR_CTRL2) |=> rdata[7])
      else $error("status clear while fault active");
   keep_osc_a: assert property (!c0[7] [*3] |-> !fast_osc_keep)
      else $error("oscillator kept while disabled");
   cover property (output_a == 2'b11 && !fault_input_pin);
   cover property ($rose(output_a.level) && c0[0]);
   cover property (rd && addr == ADDR_CTRL2 ##1 rdata[7]);
endmodule

bind cwg_core cwg_core_checker u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .fault_input_pin(fault_input_pin),
   .second_logic_cell_output(second_logic_cell_output), .output_a(output_a),
   .output_b(output_b), .fast_osc_keep(fast_osc_keep));

// ==== testbench/cwg_switch_model.sv ====
module cwg_switch_model
   import cwg_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire cwg_pkg::cwg_pin_s output_a,
   input  wire cwg_pkg::cwg_pin_s output_b,
   output logic                   gate_a,
   output logic                   gate_b,
   output logic [15:0]            overlap_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   // gate inputs have pull-downs: a released pin turns the switch off
   assign gate_a = output_a.oe ? output_a.level : 1'b0;
   assign gate_b = output_b.oe ? output_b.level : 1'b0;
   // shoot-through monitor: cycles with both switches on
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         overlap_cnt <= 16'h0000;
      else if (gate_a && gate_b)
         overlap_cnt <= overlap_cnt + 16'h0001;
   end
endmodule

// ==== testbench/test_cwg_core.sv ====
module test_cwg_core;
   timeunit 1ns;
   timeprecision 100ps;
   import cwg_pkg::*;
   logic        clk, nrst, fast_osc_tick, sleep_req, wr, rd, fault_input_pin, lc2;
   logic [2:0]  addr;         // register index
   logic [7:0]  wdata, rdata; // register data
   cwg_src_s    src_in;       // waveform sources
   cwg_pin_s    output_a, output_b;
   logic        fast_osc_keep, gate_a, gate_b;
   logic [15:0] overlap_cnt;  // shoot-through cycles seen by switches
   int          errors, tests_run, cyc, seen;
   logic [7:0]  wv [5] = '{8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
   logic [7:0]  mv [5] = '{MASK_CTRL0, MASK_CTRL1, MASK_CTRL2, MASK_DB, MASK_DB};

   cwg_core u_dut (.clk(clk), .nrst(nrst), .fast_osc_tick(fast_osc_tick),
      .sleep_req(sleep_req), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .src_in(src_in), .fault_input_pin(fault_input_pin), .second_logic_cell_output(lc2),
      .output_a(output_a), .output_b(output_b), .fast_osc_keep(fast_osc_keep));
   cwg_switch_model u_sw (.clk(clk), .nrst(nrst), .output_a(output_a),
      .output_b(output_b), .gate_a(gate_a), .gate_b(gate_b), .overlap_cnt(overlap_cnt));

   // ---------------------------------------------------------------
   // clocks, timeout and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // fast oscillator, unrelated in phase to clk
   initial
   begin
      fast_osc_tick = 1'b0;
      forever #15 fast_osc_tick = ~fast_osc_tick;
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         test_done();
      end
   end
   task automatic test_done;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1)
      begin
         $display("CHECK FAILED at %0t: %s", $time, msg);
         errors++;
      end
   endtask
   task automatic ck(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one write cycle, then one idle cycle
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata === e, "register read");
      @(posedge clk);
   endtask
   // cycles until a pin is driven at lvl, bounded by hi
   task automatic wait_pin(input bit is_b, input logic lvl, input int lo, input int hi);
      int n;
      cwg_pin_s p;
      n = 0;
      forever
      begin
         #1;
         p = is_b ? output_b : output_a;
         if ((p.oe === 1'b1 && p.level === lvl) || n > hi)
            break;
         @(posedge clk);
         n++;
      end
      chk(n >= lo && n <= hi, "pin timing");
      @(posedge clk);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      src_in = '0;
      fault_input_pin = 1'b1;
      lc2 = 1'b0;
      sleep_req = 1'b0;
      errors = 0;
      tests_run = 0;
      cyc = 0;
      ck(5);
      nrst <= 1'b1;
      ck(2);
      // reset values, then unused bits and unmapped index
      for (int i = 0; i < 5; i++)
         rd_chk(3'(i), 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(3'(i), wv[i]);
         rd_chk(3'(i), wv[i] & mv[i]);
      end
      wr_reg(3'h5, 8'hFF);
      rd_chk(3'h5, 8'h00);
      // synchronous start, overrides both low
      wr_reg(ADDR_CTRL0, 8'h00);
      wr_reg(ADDR_DBR, 8'h0A);
      wr_reg(ADDR_DBF, 8'h06);
      wr_reg(ADDR_CTRL2, 8'h83);
      wr_reg(ADDR_CTRL1, 8'hA2);
      wr_reg(ADDR_CTRL0, 8'hE0);
      ck(6);
      chk(output_a === 2'b01 && output_b === 2'b01, "start overrides");
      wr_reg(ADDR_CTRL2, 8'h03);
      rd_chk(ADDR_CTRL2, 8'h03);
      ck(12);
      chk(output_b === 2'b01, "override held");
      src_in.pwm1 <= 1'b1;
      wait_pin(0, 1'b1, 12, 16);
      chk(output_b === 2'b01, "b off");
      src_in.pwm1 <= 1'b0;
      wait_pin(1, 1'b1, 8, 12);
      chk(output_a === 2'b01, "a off");
      // pulse shorter than the rising dead band
      src_in.pwm1 <= 1'b1;
      ck(4);
      src_in.pwm1 <= 1'b0;
      seen = 0;
      repeat (30)
      begin
         @(negedge clk);
         if (output_a.level !== 1'b0)
            seen++;
      end
      @(posedge clk);
      chk(seen == 0, "short pulse");
      chk(overlap_cnt === 16'h0000, "shoot through");
      // polarity, enables
      wr_reg(ADDR_CTRL0, 8'hE8);
      ck(4);
      chk(output_a === 2'b11, "a inverted");
      wr_reg(ADDR_CTRL0, 8'hF8);
      ck(4);
      chk(output_b === 2'b01, "b inverted");
      wr_reg(ADDR_CTRL0, 8'hC0);
      ck(4);
      chk(output_a.oe === 1'b0 && output_b.oe === 1'b1, "a released");
      wr_reg(ADDR_CTRL0, 8'h00);
      ck(4);
      chk(output_a.oe === 1'b0 && output_b.oe === 1'b0, "disabled");
      // fault pin shutdown, software restart
      wr_reg(ADDR_CTRL1, 8'h72);
      wr_reg(ADDR_CTRL2, 8'h02);
      wr_reg(ADDR_CTRL0, 8'hE0);
      ck(8);
      fault_input_pin <= 1'b0;
      ck(5);
      chk(output_a === 2'b11 && output_b.oe === 1'b0, "fault overrides");
      rd_chk(ADDR_CTRL2, 8'h82);
      wr_reg(ADDR_CTRL2, 8'h02);
      ck(12);
      rd_chk(ADDR_CTRL2, 8'h82);
      fault_input_pin <= 1'b1;
      ck(4);
      wr_reg(ADDR_CTRL2, 8'h02);
      rd_chk(ADDR_CTRL2, 8'h02);
      ck(8);
      chk(output_a === 2'b11, "held after clear");
      // disabled sources have no effect
      wr_reg(ADDR_CTRL2, 8'h00);
      fault_input_pin <= 1'b0;
      lc2 <= 1'b1;
      ck(6);
      rd_chk(ADDR_CTRL2, 8'h00);
      fault_input_pin <= 1'b1;
      lc2 <= 1'b0;
      // logic cell shutdown, auto restart, software set
      wr_reg(ADDR_CTRL2, 8'h41);
      ck(8);
      lc2 <= 1'b1;
      ck(6);
      rd_chk(ADDR_CTRL2, 8'hC1);
      chk(output_b.oe === 1'b0, "b tristate");
      lc2 <= 1'b0;
      ck(6);
      rd_chk(ADDR_CTRL2, 8'h41);
      wr_reg(ADDR_CTRL2, 8'hC1);
      ck(6);
      rd_chk(ADDR_CTRL2, 8'h41);
      wr_reg(ADDR_CTRL2, 8'h80);
      ck(10);
      rd_chk(ADDR_CTRL2, 8'h80);
      wr_reg(ADDR_CTRL2, 8'h00);
      // each of the six source codes, then reserved code 0, while asleep, no dead band
      sleep_req <= 1'b1;
      wr_reg(ADDR_DBR, 8'h00);
      wr_reg(ADDR_DBF, 8'h00);
      for (int c = 2; c < 8; c++)
      begin
         wr_reg(ADDR_CTRL1, 8'hA0 | 8'(c));
         ck(8);
         src_in <= cwg_src_s'(6'h01 << (c - 2));
         wait_pin(0, 1'b1, 0, 8);
         src_in <= '0;
         wait_pin(0, 1'b0, 0, 8);
      end
      wr_reg(ADDR_CTRL1, 8'hA0);
      ck(4);
      src_in <= 6'h3F;
      ck(10);
      chk(output_a === 2'b01, "reserved source");
      src_in <= '0;
      // longest dead band on the system clock
      wr_reg(ADDR_CTRL1, 8'hA2);
      wr_reg(ADDR_DBR, 8'h3F);
      ck(8);
      src_in.pwm1 <= 1'b1;
      wait_pin(0, 1'b1, 65, 69);
      src_in.pwm1 <= 1'b0;
      // dead band counted on the fast oscillator
      wr_reg(ADDR_DBR, 8'h02);
      wr_reg(ADDR_CTRL0, 8'hE1);
      ck(10);
      src_in.pwm1 <= 1'b1;
      wait_pin(0, 1'b1, 9, 30);
      chk(fast_osc_keep === 1'b1, "osc kept");
      wr_reg(ADDR_CTRL0, 8'hE0);
      ck(3);
      chk(fast_osc_keep === 1'b0, "osc released");
      // inactive override code follows polarity
      wr_reg(ADDR_CTRL1, 8'h02);
      wr_reg(ADDR_CTRL0, 8'hE8);
      wr_reg(ADDR_CTRL2, 8'h80);
      ck(2);
      chk(output_a === 2'b11 && output_b === 2'b01, "inactive overrides");
      test_done();
   end
endmodule
